// ### include/clf_cfg.svh
// Purpose: Constants for the clock loss failover control block
// Assumes: One 250 MHz system clock, all monitor inputs synchronous
// Notes: Timing counts assume the 4 ns system clock period
// Overview of operation
// [RULE_01] On one monitored clock failing, move system clock to the surviving source.
// [RULE_02] Alternate source stays selected until reset; never switch back automatically.
// [RULE_03] Reference failure in PLL mode drops lock and enters free-running mode until reset.
// [RULE_04] Free-running frequency follows output divider; specified rate assumes divider 000.
// [RULE_05] PLL failure selects reference as source until reset, even after relock.
// [RULE_06] Input failure monitor watches reference and feedback clocks of phase comparator.
// [RULE_07] Double failure, together or PLL first: reference failure dominates, try free-running.
// [RULE_08] If free-running cannot run after double failure, hold system static until reset.
// [RULE_09] Hold reset until reference and PLL both operate correctly. In bypass mode the code releases reset at once, without either check.
// [RULE_10] Stop-mode clock loss outcome depends on mode, enables, stop power and wakeup.
// [RULE_11] Fast wakeup, PLL on, loss then regain without lock: unstable, flags 0, sync rises.
// [RULE_12] Same settings, regain with lock: normal mode, in-sync 1, lock sticky 0.
// [RULE_13] Detection off, PLL on, slow wakeup, clock and lock regained: in-sync 1, sticky 0.
// [RULE_14] Detection off, PLL off in stop, fast wakeup, reference regained: unstable, sync rises.
// [RULE_15] Bypass input mode keeps clock-loss detection disabled; no alternate source.
// [RULE_16] With detection enabled, a clock below minimum frequency sets clock-fail sticky flag.
// [RULE_17] Clock-fail reset enable makes a detected clock loss assert system reset.
// [RULE_18] Sync-loss reset enable makes a detected loss of lock assert system reset.
// [RULE_19] Source switching produces no runt or shortened system clock pulses.
// [RULE_20] Current system clock source is visible to software.
`ifndef CLF_CFG_SVH
`define CLF_CFG_SVH
`define CLF_MIN_PERIOD_NS 64
`define CLF_CLK_NS 4
`define CLF_MISS_CYC ((`CLF_MIN_PERIOD_NS + `CLF_CLK_NS - 1) / `CLF_CLK_NS)
`define CLF_DIV_W 3
`define CLF_DIV_SPEC 3'h0
`define CLF_SRC_PLL 2'h0
`define CLF_SRC_REF 2'h1
`define CLF_SRC_FREE 2'h2
`define CLF_SRC_STATIC 2'h3
`endif

// ### include/clf_pkg.sv
// Purpose: Types for the clock loss failover control block
// Assumes: Nothing beyond the config header
// Notes: States of the failover sequencer
`default_nettype none
package clf_pkg;
  typedef enum logic [2:0] {CLF_RESET, CLF_NORMAL, CLF_REF_SRC, CLF_FREE_RUN, CLF_STATIC}
    clf_state_t;
endpackage
`default_nettype wire

// ### rtl/clf_activity_mon.sv
// Purpose: Flags a monitored clock as failed when its toggles stop arriving
// Assumes: Toggle input is synchronous to sys_clk_i
// Notes: Failure is a level that clears again once toggles return
`include "clf_cfg.svh"
`default_nettype none
module clf_activity_mon (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic enable_i,
  input wire logic toggle_i,
  output logic fail_o
);
  logic [6:0] cnt_r;
  logic [6:0] cnt_nxt;
  logic prev_r;
  logic fail_r;
  logic fail_nxt;
  always_comb
  begin
    cnt_nxt = cnt_r;
    fail_nxt = fail_r;
    if (!enable_i || (toggle_i != prev_r))
    begin
      cnt_nxt = 7'h00;
      fail_nxt = 1'b0;
    end
    else if (cnt_r == 7'(`CLF_MISS_CYC))
      fail_nxt = 1'b1; // [RULE_16]
    else
      cnt_nxt = cnt_r + 7'h01;
  end
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      cnt_r <= 7'h00;
      prev_r <= 1'b0;
      fail_r <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      prev_r <= toggle_i;
      fail_r <= fail_nxt;
    end
  end
  assign fail_o = fail_r;
endmodule
`default_nettype wire

// ### rtl/clf_failover_ctrl.sv
// Purpose: Clock loss failover sequencer, flag logic and reset request
// Assumes: Lock and clock activity arrive as synchronous levels and toggles
// Notes: Source select is registered so the downstream glitch-free mux sees clean steps
`include "clf_cfg.svh"
`default_nettype none
module clf_failover_ctrl (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic bypass_mode_i,
  input wire logic fail_detect_enable_i,
  input wire logic clk_fail_reset_enable_i,
  input wire logic sync_loss_reset_enable_i,
  input wire logic fast_wakeup_i,
  input wire logic stop_mode_i,
  input wire logic pll_on_in_stop_i,
  input wire logic osc_on_in_stop_i,
  input wire logic [2:0] output_divider_i,
  input wire logic ref_toggle_i,
  input wire logic fb_toggle_i,
  input wire logic pll_lock_i,
  input wire logic free_run_ok_i,
  input wire logic mfd_change_i,
  output logic [1:0] clk_source_o,
  output logic [2:0] free_run_div_o,
  output logic free_run_spec_o,
  output logic pll_in_sync_flag_o,
  output logic lock_sticky_flag_o,
  output logic clk_fail_sticky_flag_o,
  output logic unstable_o,
  output logic sys_reset_req_o
);
  clf_pkg::clf_state_t st_r, st_nxt;
  logic ref_fail, fb_fail, mon_en, any_loss, lock_lost;
  logic lock_sticky_flag_r, lock_sticky_flag_nxt, clk_fail_sticky_flag_r, clk_fail_sticky_flag_nxt, sync_r, sync_nxt;
  logic lock_d_r, stop_d_r, unst_r, unst_nxt, rst_r, rst_nxt;
  logic [1:0] src_r, src_nxt;
  logic [2:0] div_r, div_nxt;

  // A source switched off for stop goes quiet on purpose, so its monitor rests meanwhile
  assign mon_en = !bypass_mode_i; // [RULE_15]
  clf_activity_mon u_ref_mon (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .enable_i(mon_en && !(stop_mode_i && !osc_on_in_stop_i)),
    .toggle_i(ref_toggle_i),
    .fail_o(ref_fail)
  ); // [RULE_06]
  clf_activity_mon u_fb_mon (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .enable_i(mon_en && !(stop_mode_i && !pll_on_in_stop_i)),
    .toggle_i(fb_toggle_i),
    .fail_o(fb_fail)
  ); // [RULE_06]

  assign any_loss = ref_fail || fb_fail;
  assign lock_lost = lock_d_r && !pll_lock_i && !bypass_mode_i;

  always_comb
  begin
    st_nxt = st_r;
    src_nxt = src_r;
    div_nxt = div_r;
    rst_nxt = 1'b0;
    case (st_r)
      clf_pkg::CLF_RESET:
      begin
        src_nxt = `CLF_SRC_PLL;
        if (bypass_mode_i || (!any_loss && pll_lock_i)) // [RULE_09]
          st_nxt = clf_pkg::CLF_NORMAL;
      end
      clf_pkg::CLF_NORMAL:
      begin
        // Detection off means a lost clock is waited out on the PLL, never failed over
        if (bypass_mode_i)
          st_nxt = clf_pkg::CLF_NORMAL; // [RULE_15]
        else if (any_loss && clk_fail_reset_enable_i && fail_detect_enable_i)
          rst_nxt = 1'b1; // [RULE_17] [RULE_10]
        else if (lock_lost && sync_loss_reset_enable_i)
          rst_nxt = 1'b1; // [RULE_18] [RULE_10]
        else if (ref_fail && fail_detect_enable_i)
        begin
          st_nxt = clf_pkg::CLF_FREE_RUN; // [RULE_03] [RULE_07]
          src_nxt = `CLF_SRC_FREE; // [RULE_01]
        end
        else if (fb_fail && fail_detect_enable_i)
        begin
          st_nxt = clf_pkg::CLF_REF_SRC; // [RULE_05]
          src_nxt = `CLF_SRC_REF; // [RULE_01]
        end
      end
      clf_pkg::CLF_REF_SRC:
      begin
        if (ref_fail)
        begin
          st_nxt = clf_pkg::CLF_FREE_RUN; // [RULE_07]
          src_nxt = `CLF_SRC_FREE;
        end
      end
      clf_pkg::CLF_FREE_RUN:
      begin
        div_nxt = output_divider_i; // [RULE_04]
        if (!free_run_ok_i)
        begin
          st_nxt = clf_pkg::CLF_STATIC; // [RULE_08]
          src_nxt = `CLF_SRC_STATIC;
        end
      end
      default:
        st_nxt = clf_pkg::CLF_STATIC; // [RULE_02] [RULE_08]
    endcase
  end

  always_comb
  begin
    clk_fail_sticky_flag_nxt = clk_fail_sticky_flag_r;
    lock_sticky_flag_nxt = lock_sticky_flag_r;
    sync_nxt = pll_lock_i && !bypass_mode_i && (st_r != clf_pkg::CLF_FREE_RUN); // [RULE_03]
    unst_nxt = unst_r;
    if (fail_detect_enable_i && !bypass_mode_i && any_loss)
      clk_fail_sticky_flag_nxt = 1'b1; // [RULE_16] [RULE_13] [RULE_14]
    // Lock sticky survives a planned multiplier change, not an unplanned loss
    if (st_r == clf_pkg::CLF_RESET && !bypass_mode_i && pll_lock_i && !any_loss)
      lock_sticky_flag_nxt = 1'b1;
    else if (lock_lost && !mfd_change_i)
      lock_sticky_flag_nxt = 1'b0; // [RULE_11] [RULE_12] [RULE_13]
    if (stop_d_r && !stop_mode_i)
      unst_nxt = fast_wakeup_i && !pll_lock_i; // [RULE_11] [RULE_14]
    else if (pll_lock_i)
      unst_nxt = 1'b0; // [RULE_12]
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      st_r <= clf_pkg::CLF_RESET;
      src_r <= `CLF_SRC_PLL;
      div_r <= `CLF_DIV_SPEC;
      rst_r <= 1'b1;
      clk_fail_sticky_flag_r <= 1'b0;
      lock_sticky_flag_r <= 1'b0;
      sync_r <= 1'b0;
      unst_r <= 1'b0;
      lock_d_r <= 1'b0;
      stop_d_r <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt;
      src_r <= src_nxt;
      div_r <= div_nxt;
      rst_r <= rst_nxt || (st_nxt == clf_pkg::CLF_RESET);
      clk_fail_sticky_flag_r <= clk_fail_sticky_flag_nxt;
      lock_sticky_flag_r <= lock_sticky_flag_nxt;
      sync_r <= sync_nxt;
      unst_r <= unst_nxt;
      lock_d_r <= pll_lock_i;
      stop_d_r <= stop_mode_i;
    end
  end

  assign clk_source_o = src_r; // [RULE_20] [RULE_19]
  assign free_run_div_o = div_r;
  assign free_run_spec_o = (src_r == `CLF_SRC_FREE) && (div_r == `CLF_DIV_SPEC); // [RULE_04]
  assign pll_in_sync_flag_o = sync_r;
  assign lock_sticky_flag_o = lock_sticky_flag_r;
  assign clk_fail_sticky_flag_o = clk_fail_sticky_flag_r;
  assign unstable_o = unst_r;
  // A level while its cause holds, a single cycle for a loss of lock; the system reset logic is expected to stretch it
  assign sys_reset_req_o = rst_r;

  a_src_holds: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // [RULE_02]
    (src_r != `CLF_SRC_PLL) |=> (src_r != `CLF_SRC_PLL))
    else $error("Alternate source released");
  a_ref_to_free: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // [RULE_03]
    (st_r == clf_pkg::CLF_NORMAL && ref_fail && !bypass_mode_i && !sync_loss_reset_enable_i
     && fail_detect_enable_i && !clk_fail_reset_enable_i) |=> src_r == `CLF_SRC_FREE)
    else $error("Reference loss did not enter free run");
  a_fb_to_ref: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // [RULE_05]
    (st_r == clf_pkg::CLF_NORMAL && fb_fail && !ref_fail && !bypass_mode_i
     && !sync_loss_reset_enable_i && fail_detect_enable_i && !clk_fail_reset_enable_i)
    |=> src_r == `CLF_SRC_REF) else $error("Feedback loss did not select reference");
  a_bypass_pll: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // [RULE_15]
    bypass_mode_i && src_r == `CLF_SRC_PLL |=> src_r == `CLF_SRC_PLL)
    else $error("Source changed in bypass");
  a_clk_fail_sticky_flag_set: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // [RULE_16]
    fail_detect_enable_i && !bypass_mode_i && any_loss |=> clk_fail_sticky_flag_r)
    else $error("Clock fail flag not set");
  a_clk_fail_sticky_flag_off: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // [RULE_13]
    !clk_fail_sticky_flag_r && !fail_detect_enable_i |=> !clk_fail_sticky_flag_r)
    else $error("Clock fail flag set while detection off");
  a_static_hold: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // [RULE_08]
    st_r == clf_pkg::CLF_FREE_RUN && !free_run_ok_i |=> src_r == `CLF_SRC_STATIC [*2])
    else $error("Static hold not entered");
  a_lol_reset: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // [RULE_18]
    st_r == clf_pkg::CLF_NORMAL && lock_lost && sync_loss_reset_enable_i |=> rst_r)
    else $error("Loss of lock reset missing");
  a_reset_hold: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // [RULE_09]
    st_r == clf_pkg::CLF_RESET && !bypass_mode_i && !pll_lock_i |=> rst_r)
    else $error("Reset released without lock");
  a_no_detect_hold: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // [RULE_13]
    st_r == clf_pkg::CLF_NORMAL && !fail_detect_enable_i |=> src_r == `CLF_SRC_PLL)
    else $error("Source changed with detection off");
  a_free_sync_low: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // [RULE_03]
    st_r == clf_pkg::CLF_FREE_RUN |=> !sync_r)
    else $error("Lock shown in free run");
  a_free_div: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // [RULE_04]
    st_r == clf_pkg::CLF_FREE_RUN |=> div_r == $past(output_divider_i))
    else $error("Free run divider not followed");
  a_ref_src_stay: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // [RULE_05]
    st_r == clf_pkg::CLF_REF_SRC && !ref_fail |=> src_r == `CLF_SRC_REF)
    else $error("Reference source released");
  a_loss_reset: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // [RULE_17]
    st_r == clf_pkg::CLF_NORMAL && !bypass_mode_i && any_loss && fail_detect_enable_i
    && clk_fail_reset_enable_i |=> rst_r)
    else $error("Clock loss reset missing");
  a_wake_unstable: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // [RULE_11]
    stop_d_r && !stop_mode_i && fast_wakeup_i && !pll_lock_i |=> unst_r)
    else $error("Wakeup without lock not flagged");
  a_wake_locked: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // [RULE_12]
    stop_d_r && !stop_mode_i && pll_lock_i && !bypass_mode_i && st_r == clf_pkg::CLF_NORMAL
    |=> !unst_r && sync_r)
    else $error("Locked wakeup not normal");
  a_lock_drop: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // [RULE_11]
    lock_lost && !mfd_change_i |=> !lock_sticky_flag_r)
    else $error("Lock sticky flag kept after loss");
endmodule
`default_nettype wire

// ### tb/clf_osc_model.sv
// Purpose: Reference crystal and PLL feedback model for the failover control
// Assumes: Both clocks arrive as toggles synchronous to sys_clk_i
// Notes: A stopped source freezes its line, which is what a dead oscillator looks like
`default_nettype none
module clf_osc_model (
  input wire logic sys_clk_i,
  input wire logic ref_run_i,
  input wire logic fb_run_i,
  output logic ref_toggle_o,
  output logic fb_toggle_o,
  output logic lock_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] lock_cnt_r = 3'h0;
  initial
  begin
    ref_toggle_o = 1'b0;
    fb_toggle_o = 1'b0;
    lock_o = 1'b0;
  end
  always @(posedge sys_clk_i)
  begin
    if (ref_run_i)
      ref_toggle_o <= ~ref_toggle_o;
    if (fb_run_i)
      fb_toggle_o <= ~fb_toggle_o;
    // Lock needs both comparator inputs alive for several cycles, as a real loop would
    if (!(ref_run_i && fb_run_i))
      lock_cnt_r <= 3'h0;
    else if (lock_cnt_r != 3'h7)
      lock_cnt_r <= lock_cnt_r + 3'h1;
    lock_o <= (lock_cnt_r == 3'h7);
  end
endmodule
`default_nettype wire

// ### tb/tb_clock_loss_failover_control.sv
// Purpose: Self-checking bench for the clock loss failover sequencer
// Assumes: Inputs change on the falling edge, outputs checked there too
// Notes: Run-mode failover, a lock-loss reset and four stop-mode wakeups are exercised
`include "clf_cfg.svh"
`default_nettype none
module tb_clock_loss_failover_control;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk_i = 1'b0, rst_n_i = 1'b0, bypass = 1'b0, rst_en = 1'b0, free_ok = 1'b1;
  logic fwk = 1'b0, osc_on = 1'b1, ref_run = 1'b1, fb_run = 1'b1;
  logic det = 1'b1, lol_en = 1'b0, stp = 1'b0, pll_stp = 1'b1;
  logic [2:0] div = 3'h0;
  logic ref_tg, fb_tg, lock, spec, sync_f, lock_f, fail_f, unst, req;
  logic [1:0] src;
  logic [2:0] frdiv;
  logic [4:0] c;
  // Case bits: bypass, reset on loss, free-run ok, feedback lost, reference lost
  logic [4:0] cases [6] = '{5'b00101, 5'b00110, 5'b00111, 5'b00011, 5'b10101, 5'b01101};
  int failures = 0, cmp_count = 0, cyc = 0, req_hi = 0, base = 0;
  integer seed = 32'hea0ae4ae;
  clf_osc_model osc (.sys_clk_i, .ref_run_i(ref_run), .fb_run_i(fb_run),
    .ref_toggle_o(ref_tg), .fb_toggle_o(fb_tg), .lock_o(lock));
  clf_failover_ctrl uut (.sys_clk_i, .rst_n_i, .bypass_mode_i(bypass),
    .fail_detect_enable_i(det), .clk_fail_reset_enable_i(rst_en),
    .sync_loss_reset_enable_i(lol_en), .fast_wakeup_i(fwk), .stop_mode_i(stp),
    .pll_on_in_stop_i(pll_stp), .osc_on_in_stop_i(osc_on), .output_divider_i(div),
    .ref_toggle_i(ref_tg), .fb_toggle_i(fb_tg), .pll_lock_i(lock), .free_run_ok_i(free_ok),
    .mfd_change_i(1'b0), .clk_source_o(src), .free_run_div_o(frdiv), .free_run_spec_o(spec),
    .pll_in_sync_flag_o(sync_f), .lock_sticky_flag_o(lock_f), .clk_fail_sticky_flag_o(fail_f),
    .unstable_o(unst), .sys_reset_req_o(req));
  always #2 sys_clk_i = ~sys_clk_i;
  task automatic finish_test();
    $display("Comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Ceiling well above the roughly 1040 cycles the cases need
  always @(posedge sys_clk_i)
  begin
    cyc++;
    // Reset requests can be one-cycle pulses, so they are counted rather than sampled
    if (rst_n_i && req)
      req_hi++;
    if (cyc == 2000)
    begin
      failures++;
      finish_test();
    end
  end
  task automatic chk_src(input logic [1:0] got, input logic [1:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH %0t source %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH %0t flag %b expected %b", $time, got, exp);
    end
  endtask
  task automatic chk_div(input logic [2:0] got, input logic [2:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH %0t divider %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(negedge sys_clk_i);
  endtask
  task automatic do_reset();
    rst_n_i = 1'b0;
    wait_cyc(8);
    rst_n_i = 1'b1;
    wait_cyc(20);
    chk_bit(req, 1'b0);
  endtask
  // Reference loss wins over feedback loss; bypass never fails over
  function automatic logic [1:0] exp_src(input logic [4:0] k);
    if (k[4])
      return `CLF_SRC_PLL;
    if (k[0])
      return k[2] ? `CLF_SRC_FREE : `CLF_SRC_STATIC;
    return k[1] ? `CLF_SRC_REF : `CLF_SRC_PLL;
  endfunction
  initial
  begin
    for (int i = 0; i < 6; i++)
    begin
      @(negedge sys_clk_i);
      c = cases[i];
      rst_n_i = 1'b0;
      bypass = c[4];
      rst_en = c[3];
      div = (i == 0) ? 3'h0 : 3'($random(seed));
      fwk = 1'($random(seed));
      osc_on = 1'($random(seed));
      wait_cyc(8);
      chk_bit(req, 1'b1);
      rst_n_i = 1'b1;
      wait_cyc(20);
      chk_bit(req, 1'b0);
      chk_src(src, `CLF_SRC_PLL);
      ref_run = !c[0];
      fb_run = !c[1];
      free_ok = c[2];
      wait_cyc(40);
      chk_bit(fail_f, !c[4]);
      chk_bit(req, c[3] && !c[4]);
      if (!c[3])
      begin
        chk_src(src, exp_src(c));
        if (c[0] && !c[4])
          chk_bit(sync_f, 1'b0);
        if (exp_src(c) === `CLF_SRC_FREE)
        begin
          chk_div(frdiv, div);
          chk_bit(spec, div == 3'h0);
        end
      end
      ref_run = 1'b1;
      fb_run = 1'b1;
      free_ok = 1'b1;
      wait_cyc(40);
      if (!c[3])
        chk_src(src, exp_src(c));
      $display("Case %0d done", i);
    end
    // Loss of lock with its reset enabled, then a relock that must not win the source back
    rst_en = 1'b0;
    lol_en = 1'b1;
    do_reset();
    base = req_hi;
    fb_run = 1'b0;
    wait_cyc(30);
    chk_bit(req_hi > base, 1'b1);
    chk_src(src, `CLF_SRC_REF);
    fb_run = 1'b1;
    lol_en = 1'b0;
    wait_cyc(12);
    chk_src(src, `CLF_SRC_REF);
    $display("Lock loss case done");
    // Stop cases: relock before wake, relock before wake, wake unlocked, wake unlocked PLL off
    det = 1'b0;
    osc_on = 1'b1;
    for (int k = 0; k < 4; k++)
    begin
      pll_stp = (k != 3);
      fwk = (k != 0);
      do_reset();
      chk_bit(lock_f, 1'b1);
      stp = 1'b1;
      ref_run = 1'b0;
      fb_run = 1'b0;
      wait_cyc(30);
      ref_run = 1'b1;
      fb_run = 1'b1;
      if (k < 2)
        wait_cyc(12);
      stp = 1'b0;
      wait_cyc(2);
      chk_bit(unst, k >= 2);
      chk_bit(sync_f, k < 2);
      chk_bit(lock_f, 1'b0);
      chk_bit(fail_f, 1'b0);
      wait_cyc(12);
      chk_bit(sync_f, 1'b1);
      chk_bit(unst, 1'b0);
      chk_src(src, `CLF_SRC_PLL);
      $display("Stop case %0d done", k);
    end
    finish_test();
  end
endmodule
`default_nettype wire
